/* rtl/e1c_defs.svh */
// Constants of the E1 control stream handler: bit positions, offsets, counts
`ifndef E1C_DEFS_SVH
`define E1C_DEFS_SVH
// Control word bit positions
`define E1C_CW_RSVD 7
`define E1C_CW_SI_MUX 6
`define E1C_CW_RLOOP 5
`define E1C_CW_BYPASS 4
`define E1C_CW_MAINT 3
`define E1C_CW_CRCGEN 2
`define E1C_CW_DLOOP 1
`define E1C_CW_FORCE 0
`define E1C_CW_RESET 8'h00
// Control stream channel numbers
`define E1C_CH_MFA 5'h00
`define E1C_CH_FAS 5'h10
`define E1C_CH_NFAS 5'h11
`define E1C_CH_CW 5'h12
// Multiframe frames that carry the international bits
`define E1C_FR_SI1 4'hD
`define E1C_FR_SI2 4'hF
// CRC multiframe alignment pattern in odd frames 1 to 11, frame 1 at top
`define E1C_CRC_MFA 6'h0B
// Timing
`define E1C_CLK_KHZ 10000
`define E1C_MF_WAIT_MS 8
`define E1C_ERR_WIN_MS 1000
`define E1C_ERR_LIMIT 914
`define E1C_BIT_DIV 8
`define E1C_RF_FRAMES 2
// Host register byte offsets
`define E1C_R_CW 6'h00
`define E1C_R_MFA 6'h04
`define E1C_R_FAS 6'h08
`define E1C_R_NFAS 6'h0C
`define E1C_R_SIG 6'h10
`define E1C_R_RXMFA 6'h14
`define E1C_R_STAT 6'h18
`define E1C_R_FORCE_FRAME_SEARCH 6'h1C
`define E1C_R_DTX 6'h20
`define E1C_R_DRX 6'h24
// Host register reset values
`define E1C_MFA_RESET 8'h0B
`define E1C_FAS_RESET 8'h9B
`define E1C_NFAS_RESET 8'hDF
`define E1C_SIG_RESET 8'hDD
`define E1C_DTX_RESET 8'hFF
`endif

/* rtl/e1c_pkg.sv */
// Types shared by both ends of the E1 control stream handler
package e1c_pkg;
  typedef logic [7:0] e1c_byte_t;
  typedef logic [7:0] e1c_bit_idx_t;
  typedef enum logic [1:0] {
    E1C_RF_IDLE = 2'b01,
    E1C_RF_HOLD = 2'b10
  } e1c_rf_state_t;
endpackage : e1c_pkg

/* rtl/e1c_link_if.sv */
// Serial bus link between host controller and framer
`timescale 1ns/1ps
interface e1c_link_if;
  logic bus_clk;
  logic frame_sync;
  logic ctl_in;
  logic ctl_out;
  logic data_in;
  logic data_out;
  modport host (
    output bus_clk,
    output frame_sync,
    output ctl_in,
    output data_in,
    input ctl_out,
    input data_out
  );
  modport dev (
    input bus_clk,
    input frame_sync,
    input ctl_in,
    input data_in,
    output ctl_out,
    output data_out
  );
endinterface : e1c_link_if

/* rtl/e1c_sync.sv */
// Two-flop synchroniser with edge detection on bit 0
`timescale 1ns/1ps
module e1c_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic rise,
  output logic fall
);
  logic [W-1:0] meta_reg;
  logic prev_reg;
  // First stage feeds only the second stage
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q <= '0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
      prev_reg <= q[0];
    end
  end
  assign rise = q[0] & ~prev_reg;
  assign fall = ~q[0] & prev_reg;
endmodule : e1c_sync

/* rtl/e1c_dev_end.sv */
// Framer end: control word decode, timeslot mapping, maintenance reframe
// Function
// RULE1: Host keeps control word bit 7 zero
// RULE2: Multiplexing sends sub-multiframe CRC results frames 13/15
// RULE3: Remote loop routes tip/ring to outputs A/B
// RULE4: Bit 4 bypasses HDB3 line coding
// RULE5: Maintenance reframes if no CRC multiframe in 8ms
// RULE6: Maintenance reframes above 914 CRC errors/second
// RULE7: Bit 2 enables transmit CRC generation
// RULE8: Receive CRC checking always runs
// RULE9: Local loop returns data input to output
// RULE10: Reframe only on falling force bit
// RULE11: Host holds force bit a frame, clears
// RULE12: Received MFA bits 1-4 to output bits 7-4
// RULE13: Received bit 5 to output bit 3
// RULE14: Received bit 6 remote alarm to bit 2
// RULE15: Received bits 7,8 to output bits 1,0
// RULE16: Input channel 0 goes to frame-0 timeslot 16
// RULE17: Channels 1-15 carry signalling for two timeslots
// RULE18: Channels 16/17 give alignment and non-alignment bytes
// RULE19: Channel 18 carries the control word
// RULE20: Multiplexing with CRC ignores host international bit
// RULE21: Upper nibble positions 1-4, lower 5-8
// RULE22: Control word applied from next frame boundary
//
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`include "e1c_defs.svh"
module e1c_dev_end #(
  parameter int MF_WAIT_CYC = `E1C_MF_WAIT_MS * `E1C_CLK_KHZ,
  parameter int ERR_WIN_CYC = `E1C_ERR_WIN_MS * 1000 * (`E1C_CLK_KHZ / 1000),
  parameter int ERR_LIMIT = `E1C_ERR_LIMIT
) (
  input wire logic clock,
  input wire logic rst_n,
  e1c_link_if.dev link,
  input wire logic line_rx_tip,
  input wire logic line_rx_ring,
  input wire logic tx_line_a,
  input wire logic tx_line_b,
  input wire logic rx_data_bit,
  input wire logic rx_frame_locked,
  input wire logic rx_mf_locked,
  input wire logic rx_crc_error,
  input wire logic rx_smf1_crc_ok,
  input wire logic rx_smf2_crc_ok,
  input wire logic rx_mfa_valid,
  input wire e1c_pkg::e1c_byte_t rx_mfa_byte,
  output logic line_out_a,
  output logic line_out_b,
  output logic line_code_bypass,
  output logic tx_check_generate,
  output logic frame_search_start,
  output e1c_pkg::e1c_byte_t tx_ts0_byte,
  output e1c_pkg::e1c_byte_t tx_ts16_byte,
  output logic [3:0] tx_frame_num,
  output logic tx_frame_strobe
);
  import e1c_pkg::*;

  logic [5:0] sync_q;
  logic bit_rise, bit_fall;
  logic ctl_s, dat_s, fs_s, tip_s, ring_s;
  e1c_bit_idx_t idx_reg, idx_next, out_idx;
  logic [6:0] sh_reg;
  e1c_byte_t got_byte;
  logic byte_done, frame_bnd, bnd_d_reg;
  e1c_byte_t cw_reg, cw_pend_reg, mfa_tx_reg, fas_reg, nfas_reg, rx_mfa_reg;
  e1c_byte_t sig_mem [1:15];
  logic [3:0] mf_reg;
  logic smf1_res_reg, smf2_res_reg, dat_last_reg, si_bit;
  logic rf_edge, rf_mf, rf_err;
  logic [31:0] mfw_cnt_reg, win_cnt_reg;
  logic [10:0] err_cnt_reg;

  ////////////////////////////////////////////////////////////////////////
  // Every pin from the bus or the line passes two flops first
  e1c_sync #(.W(6)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .d({line_rx_ring, line_rx_tip, link.frame_sync, link.data_in,
        link.ctl_in, link.bus_clk}),
    .q(sync_q),
    .rise(bit_rise),
    .fall(bit_fall)
  );
  assign {ring_s, tip_s, fs_s, dat_s, ctl_s} = sync_q[5:1];

  ////////////////////////////////////////////////////////////////////////
  // Bit position: frame sync marks bit 0 of channel 0
  assign idx_next = fs_s ? 8'h00 : idx_reg + 8'h01;
  assign frame_bnd = bit_rise & fs_s;
  assign byte_done = bit_rise & (idx_next[2:0] == 3'h7);
  assign got_byte = {sh_reg, ctl_s};
  assign out_idx = idx_reg + 8'h01;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      idx_reg <= 8'h00;
      sh_reg <= 7'h00;
      dat_last_reg <= 1'b1;
    end else if (bit_rise) begin
      idx_reg <= idx_next;
      sh_reg <= got_byte[6:0];
      dat_last_reg <= dat_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Channel capture from the control input stream, MSB first
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cw_pend_reg <= `E1C_CW_RESET;
      mfa_tx_reg <= 8'hFF;
      fas_reg <= 8'hFF;
      nfas_reg <= 8'hFF;
    end else if (byte_done) begin
      unique case (idx_next[7:3])
        `E1C_CH_MFA: mfa_tx_reg <= got_byte; // [RULE16]
        `E1C_CH_FAS: fas_reg <= got_byte; // [RULE18]
        `E1C_CH_NFAS: nfas_reg <= got_byte; // [RULE18]
        `E1C_CH_CW: cw_pend_reg <= got_byte; // [RULE19]
        default: ;
      endcase
    end
  end

  // Signalling bytes for frames 1 to 15
  always_ff @(posedge clock) begin
    if (byte_done && idx_next[7:3] != 5'h00 && idx_next[7:4] == 4'h0) begin
      sig_mem[idx_next[6:3]] <= got_byte; // [RULE17]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Word taken mid-frame only acts at the next boundary, so a setting
  // never changes half way through a frame
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cw_reg <= `E1C_CW_RESET;
    end else if (frame_bnd) begin
      cw_reg <= cw_pend_reg; // [RULE22]
    end
  end
  // A steady low never retriggers; only the 1 to 0 step counts
  assign rf_edge = frame_bnd & cw_reg[`E1C_CW_FORCE] &
                   ~cw_pend_reg[`E1C_CW_FORCE]; // [RULE10]

  ////////////////////////////////////////////////////////////////////////
  // Multiframe counter and outgoing timeslot bytes
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mf_reg <= 4'h0;
      bnd_d_reg <= 1'b0;
      smf1_res_reg <= 1'b1;
      smf2_res_reg <= 1'b1;
    end else begin
      bnd_d_reg <= frame_bnd;
      if (frame_bnd) begin
        mf_reg <= mf_reg + 4'h1;
        smf1_res_reg <= rx_smf1_crc_ok;
        smf2_res_reg <= rx_smf2_crc_ok;
      end
    end
  end

  // International bit of non-alignment frames
  always_comb begin
    si_bit = nfas_reg[7];
    if (cw_reg[`E1C_CW_CRCGEN]) begin
      if (mf_reg == `E1C_FR_SI1) begin
        si_bit = cw_reg[`E1C_CW_SI_MUX] ? smf1_res_reg :
                 nfas_reg[7]; // [RULE2]
      end else if (mf_reg == `E1C_FR_SI2) begin
        si_bit = cw_reg[`E1C_CW_SI_MUX] ? smf2_res_reg :
                 nfas_reg[7]; // [RULE20]
      end else begin
        si_bit = 1'(`E1C_CRC_MFA >> (3'h5 - mf_reg[3:1]));
      end
    end
  end

  // Bytes for the frame just begun; even frames carry alignment
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tx_ts0_byte <= 8'hFF;
      tx_ts16_byte <= 8'hFF;
      tx_frame_num <= 4'h0;
      tx_frame_strobe <= 1'b0;
    end else begin
      tx_frame_strobe <= bnd_d_reg;
      if (bnd_d_reg) begin
        tx_frame_num <= mf_reg;
        tx_ts0_byte <= mf_reg[0] ? {si_bit, nfas_reg[6:0]} : fas_reg;
        // Upper nibble lands in positions 1-4, lower in 5-8 [RULE21]
        tx_ts16_byte <= (mf_reg == 4'h0) ? mfa_tx_reg :
                        sig_mem[mf_reg]; // [RULE16] [RULE17]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Maintenance: wait for CRC multiframe after frame lock
  always_ff @(posedge clock) begin
    if (!rst_n || !rx_frame_locked || rx_mf_locked || rf_mf) begin
      mfw_cnt_reg <= 32'h0;
    end else begin
      mfw_cnt_reg <= mfw_cnt_reg + 32'h1;
    end
  end
  assign rf_mf = cw_reg[`E1C_CW_MAINT] &&
                 mfw_cnt_reg == 32'(MF_WAIT_CYC - 1); // [RULE5]

  // Error window; the checker counts even with CRC generation off.
  // An error on the window's last cycle is kept for the next, not lost to the clear.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      win_cnt_reg <= 32'h0;
      err_cnt_reg <= 11'h000;
    end else if (win_cnt_reg == 32'(ERR_WIN_CYC - 1)) begin
      win_cnt_reg <= 32'h0;
      err_cnt_reg <= {10'h000, rx_crc_error}; // [RULE6]
    end else begin
      win_cnt_reg <= win_cnt_reg + 32'h1;
      if (rx_crc_error && err_cnt_reg != 11'h7FF) begin
        err_cnt_reg <= err_cnt_reg + 11'h001; // [RULE8]
      end
    end
  end
  // Fires once, on the error that passes the limit
  assign rf_err = cw_reg[`E1C_CW_MAINT] & rx_crc_error &
                  (err_cnt_reg == 11'(ERR_LIMIT)) &
                  (win_cnt_reg != 32'(ERR_WIN_CYC - 1)); // [RULE6]

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      frame_search_start <= 1'b0;
    end else begin
      frame_search_start <= rf_edge | rf_mf | rf_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Received frame-0 timeslot 16 byte, passed through undebounced
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rx_mfa_reg <= 8'hFF;
    end else if (rx_mfa_valid) begin
      rx_mfa_reg <= rx_mfa_byte; // [RULE12] [RULE13] [RULE14] [RULE15]
    end
  end

  // Serial outputs change on the bus clock's falling edge for next bit.
  // Looped data lags the input by one bit time.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      link.ctl_out <= 1'b1;
      link.data_out <= 1'b1;
    end else if (bit_fall) begin
      link.ctl_out <= (out_idx[7:3] == `E1C_CH_MFA) ?
                      rx_mfa_reg[3'h7 - out_idx[2:0]] : 1'b1;
      link.data_out <= cw_reg[`E1C_CW_DLOOP] ? dat_last_reg :
                       rx_data_bit; // [RULE9]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Line side outputs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      line_out_a <= 1'b0;
      line_out_b <= 1'b0;
      line_code_bypass <= 1'b0;
      tx_check_generate <= 1'b0;
    end else begin
      line_out_a <= cw_reg[`E1C_CW_RLOOP] ? tip_s : tx_line_a; // [RULE3]
      line_out_b <= cw_reg[`E1C_CW_RLOOP] ? ring_s : tx_line_b; // [RULE3]
      line_code_bypass <= cw_reg[`E1C_CW_BYPASS]; // [RULE4]
      tx_check_generate <= cw_reg[`E1C_CW_CRCGEN]; // [RULE7]
    end
  end
endmodule : e1c_dev_end

/* rtl/e1c_host_end.sv */
// Host end: Avalon registers, bus clock divider, control stream source
`timescale 1ns/1ps
`include "e1c_defs.svh"
module e1c_host_end (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  e1c_link_if.host link
);
  import e1c_pkg::*;

  logic ack_reg, wr_ok, fall_ev;
  e1c_byte_t cw_reg, mfa_reg, fas_reg, nfas_reg, sig_reg, dtx_reg;
  e1c_byte_t rx_mfa_reg, drx_reg, src_byte, cw_tx;
  logic [6:0] rsh_reg, dsh_reg;
  logic [2:0] div_reg;
  e1c_bit_idx_t idx_reg, idx_next;
  logic [1:0] in_q;
  logic [1:0] rf_cnt_reg;
  e1c_rf_state_t rf_state;

  ////////////////////////////////////////////////////////////////////////
  // One wait state on every access
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign wr_ok = avs_write & ack_reg;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      avs_readdata <= 32'h0;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
      if (avs_read && !ack_reg) begin
        unique case (avs_address)
          `E1C_R_CW: avs_readdata <= {24'h0, cw_reg};
          `E1C_R_MFA: avs_readdata <= {24'h0, mfa_reg};
          `E1C_R_FAS: avs_readdata <= {24'h0, fas_reg};
          `E1C_R_NFAS: avs_readdata <= {24'h0, nfas_reg};
          `E1C_R_SIG: avs_readdata <= {24'h0, sig_reg};
          `E1C_R_RXMFA: avs_readdata <= {24'h0, rx_mfa_reg};
          `E1C_R_STAT: avs_readdata <= {31'h0, rf_state == E1C_RF_HOLD};
          `E1C_R_DTX: avs_readdata <= {24'h0, dtx_reg};
          `E1C_R_DRX: avs_readdata <= {24'h0, drx_reg};
          default: avs_readdata <= 32'h0;
        endcase
      end
    end
  end

  // Writable registers; reserved bit 7 never leaves as one [RULE1]
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cw_reg <= `E1C_CW_RESET;
      mfa_reg <= `E1C_MFA_RESET;
      fas_reg <= `E1C_FAS_RESET;
      nfas_reg <= `E1C_NFAS_RESET;
      sig_reg <= `E1C_SIG_RESET;
      dtx_reg <= `E1C_DTX_RESET;
    end else if (wr_ok) begin
      unique case (avs_address)
        `E1C_R_CW: cw_reg <= {1'b0, avs_writedata[6:1], 1'b0}; // [RULE1]
        `E1C_R_MFA: mfa_reg <= avs_writedata[7:0];
        `E1C_R_FAS: fas_reg <= avs_writedata[7:0];
        `E1C_R_NFAS: nfas_reg <= avs_writedata[7:0];
        `E1C_R_SIG: sig_reg <= avs_writedata[7:0];
        `E1C_R_DTX: dtx_reg <= avs_writedata[7:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Force bit held for whole frames, then dropped by hardware, so
  // software cannot make a pulse shorter than a frame
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rf_state <= E1C_RF_IDLE;
      rf_cnt_reg <= 2'h0;
    end else begin
      unique case (rf_state)
        E1C_RF_IDLE: begin
          rf_cnt_reg <= 2'h0;
          if (wr_ok && avs_address == `E1C_R_FORCE_FRAME_SEARCH && avs_writedata[0]) begin
            rf_state <= E1C_RF_HOLD;
          end
        end
        E1C_RF_HOLD: begin
          if (fall_ev && idx_next == 8'h00) begin
            rf_cnt_reg <= rf_cnt_reg + 2'h1;
            if (rf_cnt_reg == 2'(`E1C_RF_FRAMES)) begin
              rf_state <= E1C_RF_IDLE; // [RULE11]
            end
          end
        end
      endcase
    end
  end
  assign cw_tx = {cw_reg[7:1], rf_state == E1C_RF_HOLD}; // [RULE11]

  ////////////////////////////////////////////////////////////////////////
  // Bus clock: low for the first half of each bit period, rising mid-bit
  assign fall_ev = div_reg == 3'(`E1C_BIT_DIV / 2 - 1);
  assign idx_next = idx_reg + 8'h01;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      div_reg <= 3'h7; // Last phase: first high half is full length
      link.bus_clk <= 1'b0;
    end else begin
      div_reg <= div_reg + 3'h1;
      link.bus_clk <= ~div_reg[2] ^ (div_reg == 3'h7) ^ fall_ev;
    end
  end

  // Byte offered on each control channel
  always_comb begin
    unique case (idx_next[7:3])
      `E1C_CH_MFA: src_byte = mfa_reg; // [RULE16]
      `E1C_CH_FAS: src_byte = fas_reg; // [RULE18]
      `E1C_CH_NFAS: src_byte = nfas_reg; // [RULE18]
      `E1C_CH_CW: src_byte = cw_tx; // [RULE19]
      default: src_byte = (idx_next[7:4] == 4'h0) ? sig_reg : 8'hFF;
    endcase
  end

  e1c_sync #(.W(2)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .d({link.data_out, link.ctl_out}),
    .q(in_q),
    .rise(),
    .fall()
  );

  // Sample the finished bit, then drive the next one
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      idx_reg <= 8'hFF;
      link.frame_sync <= 1'b0;
      link.ctl_in <= 1'b1;
      link.data_in <= 1'b1;
      rsh_reg <= 7'h7F;
      dsh_reg <= 7'h7F;
      rx_mfa_reg <= 8'hFF;
      drx_reg <= 8'hFF;
    end else if (fall_ev) begin
      idx_reg <= idx_next;
      link.frame_sync <= idx_next == 8'h00;
      link.ctl_in <= src_byte[3'h7 - idx_next[2:0]]; // [RULE17]
      link.data_in <= dtx_reg[3'h7 - idx_next[2:0]];
      rsh_reg <= {rsh_reg[5:0], in_q[0]};
      dsh_reg <= {dsh_reg[5:0], in_q[1]};
      if (idx_reg == 8'h07) begin
        rx_mfa_reg <= {rsh_reg, in_q[0]};
      end
      if (idx_reg == 8'h0F) begin
        drx_reg <= {dsh_reg, in_q[1]};
      end
    end
  end
endmodule : e1c_host_end

/* verification/e1c_link_props.sv */
// Checker on the link between the two ends and the framer's outputs
`timescale 1ns/1ps
module e1c_link_props (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic bus_clk,
  input wire logic frame_sync,
  input wire logic ctl_in,
  input wire logic data_out,
  input wire logic frame_search_start,
  input wire logic tx_frame_strobe,
  input wire logic [3:0] tx_frame_num,
  input wire logic line_code_bypass,
  input wire logic tx_check_generate
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic seen_reg;
  logic [3:0] num_reg;
  //////////////////////////////////////////////////////////////////////////
  // Last frame number, so each strobe can be tied to the one before
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      seen_reg <= 1'b0;
      num_reg <= 4'h0;
    end else if (tx_frame_strobe) begin
      seen_reg <= 1'b1;
      num_reg <= tx_frame_num;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Bit clock shape and framing on the wire
  bit_clk_shape_a: assert property ($rose(bus_clk) |->
    bus_clk [*4] ##1 !bus_clk [*4] ##1 bus_clk)
    else $error("bus clock period is not eight cycles");
  sync_width_a: assert property ($rose(frame_sync) |->
    frame_sync [*8] ##1 !frame_sync)
    else $error("frame sync is not one bit long");
  sync_phase_a: assert property ($rose(frame_sync) |-> !bus_clk)
    else $error("frame sync moved while bus clock high");
  ctl_hold_a: assert property ($rose(bus_clk) |->
    $stable(ctl_in) [*3])
    else $error("control input moved while sampled");
  data_hold_a: assert property ($rose(bus_clk) |=>
    $stable(data_out) [*2])
    else $error("data output moved while sampled");
  // One pulse per frame search request
  search_pulse_a: assert property (frame_search_start |=>
    !frame_search_start [*8])
    else $error("frame search pulse longer than one cycle");
  frame_step_a: assert property (tx_frame_strobe && seen_reg |->
    tx_frame_num == num_reg + 4'h1)
    else $error("frame number did not step by one");
  // Settings only move at a frame boundary
  bypass_edge_a: assert property ($changed(line_code_bypass) |->
    ##[0:4] tx_frame_strobe)
    else $error("line code bypass changed off a frame boundary");
  crcgen_edge_a: assert property ($changed(tx_check_generate) |->
    ##[0:4] tx_frame_strobe)
    else $error("check generate changed off a frame boundary");
endmodule : e1c_link_props

/* verification/e1_control_stream_handler_tb.sv */
// Testbench: both ends joined, driven over Avalon, frames compared to a model
`timescale 1ns/1ps
`include "e1c_defs.svh"
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin num_errors++; \
  $display("wrong value %s exp %0h got %0h", n, e, s); end end
module e1_control_stream_handler_tb;
  import e1c_pkg::*;
  localparam int MFW = 300;
  logic clock = 0, rst_n = 0, avs_read = 0, avs_write = 0;
  logic [5:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, q, rnd = 32'hCFFE;
  logic avs_waitrequest, line_out_a, line_out_b, line_code_bypass;
  logic tx_check_generate, frame_search_start, tx_frame_strobe;
  logic line_rx_tip = 0, line_rx_ring = 0, rx_frame_locked = 0;
  logic rx_mf_locked = 1, rx_crc_error = 0, rx_mfa_valid = 0;
  logic rx_smf1_crc_ok = 0, rx_smf2_crc_ok = 0, crc, si_mux;
  e1c_byte_t rx_mfa_byte = 0, tx_ts0_byte, tx_ts16_byte;
  e1c_byte_t mfa, fas, nfas, sig, dtx;
  logic [3:0] tx_frame_num;
  int num_errors = 0, n_checks = 0, srch = 0, sr, i;
  logic [5:0] ra[6] = '{`E1C_R_MFA, `E1C_R_FAS, `E1C_R_NFAS, `E1C_R_SIG,
    `E1C_R_DTX, 6'h3C};
  e1c_byte_t rv[6] = '{`E1C_MFA_RESET, `E1C_FAS_RESET, `E1C_NFAS_RESET,
    `E1C_SIG_RESET, `E1C_DTX_RESET, 8'h00};
  e1c_link_if e1c_link_if_inst ();
  e1c_host_end e1c_host_end_inst (.clock(clock), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link(e1c_link_if_inst));
  e1c_dev_end #(.MF_WAIT_CYC(MFW), .ERR_WIN_CYC(4000), .ERR_LIMIT(3))
    e1c_dev_end_inst (.clock(clock), .rst_n(rst_n), .link(e1c_link_if_inst),
    .line_rx_tip(line_rx_tip), .line_rx_ring(line_rx_ring),
    .tx_line_a(line_rx_ring), .tx_line_b(line_rx_tip),
    .rx_data_bit(line_rx_ring),
    .rx_frame_locked(rx_frame_locked), .rx_mf_locked(rx_mf_locked),
    .rx_crc_error(rx_crc_error), .rx_smf1_crc_ok(rx_smf1_crc_ok),
    .rx_smf2_crc_ok(rx_smf2_crc_ok), .rx_mfa_valid(rx_mfa_valid),
    .rx_mfa_byte(rx_mfa_byte), .line_out_a(line_out_a),
    .line_out_b(line_out_b), .line_code_bypass(line_code_bypass),
    .tx_check_generate(tx_check_generate),
    .frame_search_start(frame_search_start), .tx_ts0_byte(tx_ts0_byte),
    .tx_ts16_byte(tx_ts16_byte), .tx_frame_num(tx_frame_num),
    .tx_frame_strobe(tx_frame_strobe));
  e1c_link_props e1c_link_props_inst (.clock(clock), .rst_n(rst_n),
    .bus_clk(e1c_link_if_inst.bus_clk),
    .frame_sync(e1c_link_if_inst.frame_sync),
    .ctl_in(e1c_link_if_inst.ctl_in), .data_out(e1c_link_if_inst.data_out),
    .frame_search_start(frame_search_start),
    .tx_frame_strobe(tx_frame_strobe), .tx_frame_num(tx_frame_num),
    .line_code_bypass(line_code_bypass),
    .tx_check_generate(tx_check_generate));
  //////////////////////////////////////////////////////////////////////////
  // Clock, and a count of frame search pulses
  initial begin
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    if (frame_search_start === 1'b1) srch <= srch + 1;
  end
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Model of timeslot 0: alignment byte, or non-alignment with the Si bit
  function e1c_byte_t exp_ts0(input logic [3:0] f);
    logic [5:0] pat;
    logic si;
    pat = `E1C_CRC_MFA;
    if (!f[0]) return fas;
    si = nfas[7];
    if (crc && f <= 4'hB) si = pat[(11 - f) / 2];
    if (crc && si_mux && f == `E1C_FR_SI1) si = rx_smf1_crc_ok;
    if (crc && si_mux && f == `E1C_FR_SI2) si = rx_smf2_crc_ok;
    return {si, nfas[6:0]};
  endfunction : exp_ts0
  task wrap_up;
    if (num_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  // One Avalon transfer; holds the request until waitrequest is seen low
  task av(input logic w, input logic [5:0] a, input e1c_byte_t d);
    int k;
    begin
      avs_address <= a[5:0];
      avs_writedata <= {24'h0, d};
      avs_write <= w;
      avs_read <= !w;
      for (k = 0; k < 20; k++) begin
        @(posedge clock);
        if (avs_waitrequest === 1'b0) break;
      end
      q = avs_readdata;
      avs_read <= 0;
      avs_write <= 0;
      if (k == 20) begin
        num_errors++;
        wrap_up();
      end
      @(posedge clock);
    end
  endtask : av
  // Waits n frame strobes, optionally comparing the frame bytes to the model
  task frames(input int n, input bit chk);
    int k;
    repeat (n) begin
      for (k = 0; k < 3000; k++) begin
        @(posedge clock);
        if (tx_frame_strobe === 1'b1) break;
      end
      if (k == 3000) begin
        num_errors++;
        wrap_up();
      end
      if (chk) begin
        `CHK("ts0", exp_ts0(tx_frame_num), tx_ts0_byte)
        `CHK("ts16", tx_frame_num == 0 ? mfa : sig, tx_ts16_byte)
      end
    end
  endtask : frames
  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1;
    @(posedge clock);
    for (i = 0; i < 6; i++) begin
      av(0, ra[i], 0);
      `CHK("reset", {24'h0, rv[i]}, q)
    end
    rnd = lfsr(rnd);
    mfa = {4'h0, rnd[3:0]};
    {sig, nfas, fas} = rnd[31:8];
    rnd = lfsr(rnd);
    dtx = rnd[7:0];
    av(1, `E1C_R_MFA, mfa);
    av(1, `E1C_R_FAS, fas);
    av(1, `E1C_R_NFAS, nfas);
    av(1, `E1C_R_SIG, sig);
    av(1, `E1C_R_DTX, dtx);
    // Reserved and force bits cannot be set from the control register
    {crc, si_mux} = 2'b00;
    av(1, `E1C_R_CW, 8'h93);
    av(0, `E1C_R_CW, 0);
    `CHK("cw", 32'h12, q)
    frames(3, 0);
    frames(6, 1);
    `CHK("bypass", 1'b1, line_code_bypass)
    `CHK("crcgen", 1'b0, tx_check_generate)
    av(0, `E1C_R_DRX, 0);
    // Looped data lags one bit, so the byte comes back rotated by one
    `CHK("drx", {24'h0, dtx[0], dtx[7:1]}, q)
    rnd = lfsr(rnd);
    rx_smf1_crc_ok <= rnd[0];
    rx_smf2_crc_ok <= rnd[1];
    {crc, si_mux} = 2'b11;
    av(1, `E1C_R_CW, 8'h6C);
    frames(3, 0);
    frames(16, 1);
    `CHK("bypass", 1'b0, line_code_bypass)
    `CHK("crcgen", 1'b1, tx_check_generate)
    // Each line level held a whole bit so the synchroniser lag is moot
    for (i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      line_rx_tip <= rnd[0];
      line_rx_ring <= rnd[1];
      repeat (8) @(posedge clock);
      `CHK("out_a", rnd[0], line_out_a)
      `CHK("out_b", rnd[1], line_out_b)
    end
    rx_mfa_byte <= rnd[15:8];
    rx_mfa_valid <= 1;
    @(posedge clock);
    rx_mfa_valid <= 0;
    frames(2, 0);
    av(0, `E1C_R_RXMFA, 0);
    `CHK("rxmfa", {24'h0, rnd[15:8]}, q)
    sr = srch;
    rx_frame_locked <= 1;
    rx_mf_locked <= 0;
    repeat (MFW - 10) @(posedge clock);
    `CHK("mf_early", sr, srch)
    repeat (20) @(posedge clock);
    `CHK("mf_wait", sr + 1, srch)
    rx_mf_locked <= 1;
    // Errors counted with the transmit check generator off
    av(1, `E1C_R_CW, 8'h08);
    frames(3, 0);
    sr = srch;
    for (i = 0; i < 4; i++) begin
      rx_crc_error <= 1;
      @(posedge clock);
      rx_crc_error <= 0;
      repeat (5) @(posedge clock);
      `CHK("err_cnt", sr + (i == 3), srch)
    end
    sr = srch;
    // Both loops off now: normal line drive and received data pass
    `CHK("out_a", line_rx_ring, line_out_a)
    `CHK("out_b", line_rx_tip, line_out_b)
    av(0, `E1C_R_DRX, 0);
    `CHK("drx", {24'h0, {8{line_rx_ring}}}, q)
    av(1, `E1C_R_FORCE_FRAME_SEARCH, 8'h01);
    av(0, `E1C_R_STAT, 0);
    `CHK("busy", 32'h1, q)
    frames(6, 0);
    `CHK("reframe", sr + 1, srch)
    wrap_up();
  end
endmodule : e1_control_stream_handler_tb
